// ---- rtl/dac_cmd_top.sv ----
`timescale 1ns/1ps
`include "dac_regs.svh"


module dac_cmd_top
  import dac_pkg::*;
(
  // Reference clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  // Serial link pins
  input  wire logic                  SHIFT_CLK,
  input  wire logic                  CHIP_SELECT_N,
  input  wire logic                  CHAIN_SERIAL_IN,
  output logic                       CHAIN_SERIAL_OUT,
  output logic                       CHAIN_SERIAL_OUT_OE,
  // Hardware latch control
  input  wire logic                  LOAD_LATCH_N,
  // Command flow
  input  wire logic                  CMD_STALL,
  output logic                       WORD_DONE,
  output logic                       SHORT_WORD,
  output logic                       ECHO_MODE,
  // Converter codes
  output logic [`CODE_BITS-1:0]      DAC_CODE_A,
  output logic [`CODE_BITS-1:0]      DAC_CODE_B,
  output logic [`CODE_BITS-1:0]      DAC_CODE_C,
  output logic [`CODE_BITS-1:0]      DAC_CODE_D
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  word_type                          link_word;
  logic                              link_full;
  logic                              cs_meta;
  logic                              cs_sync;
  logic                              full_meta;
  logic                              full_sync;
  logic                              latch_meta;
  logic                              latch_sync;
  cap_state_type                     state;
  cap_state_type                     next_state;
  word_type                          pend_word;
  logic                              frame_end;
  logic                              exec;
  cmd_word_type                      cmd;
  logic                              mode;
  logic [`CHANNELS-1:0][`CODE_BITS-1:0] input_code;
  logic [`CHANNELS-1:0][`CODE_BITS-1:0] next_input;
  logic [`CHANNELS-1:0][`CODE_BITS-1:0] dac_code;

  word_stream_if fill_bus ();
  word_stream_if drain_bus ();

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Channel index from the two address bits
  function automatic logic [1:0] chan_index(input cmd_word_type c);
    chan_index = {c.addr_bit_hi, c.addr_bit_lo};
  endfunction

  // Control field as one value
  function automatic logic [1:0] ctrl_field(input cmd_word_type c);
    ctrl_field = {c.ctrl_bit_hi, c.ctrl_bit_lo};
  endfunction

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------

  // Shift register and serial output on the link clock
  serial_link link (
    .shift_clk     (SHIFT_CLK),
    .rst           (RST),
    .chip_select_n (CHIP_SELECT_N),
    .serial_in     (CHAIN_SERIAL_IN),
    .serial_out    (CHAIN_SERIAL_OUT),
    .serial_out_oe (CHAIN_SERIAL_OUT_OE),
    .mode_ref      (mode),
    .word          (link_word),
    .word_full     (link_full)
  );

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------

  // Select, bit-count flag and latch pin cross two flops each
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cs_meta    <= 1'b1;
      cs_sync    <= 1'b1;
      full_meta  <= 1'b0;
      full_sync  <= 1'b0;
      latch_meta <= 1'b1;
      latch_sync <= 1'b1;
    end else begin
      cs_meta    <= CHIP_SELECT_N;
      cs_sync    <= cs_meta;
      full_meta  <= link_full;
      full_sync  <= full_meta;
      latch_meta <= LOAD_LATCH_N;
      latch_sync <= latch_meta;
    end
  end

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------

  // The frame ends when the synced select goes high again
  assign frame_end = (state == ST_FRAME) && cs_sync;

  // Next state of the capture tracker
  always_comb begin
    next_state = state;
    unique case (state)
      ST_WAIT: begin
        if (!cs_sync) begin
          next_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_sync) begin
          next_state = full_sync ? ST_OFFER : ST_WAIT;
        end
      end
      ST_OFFER: begin
        if (fill_bus.ready) begin
          next_state = cs_sync ? ST_WAIT : ST_FRAME;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // The link word is static once select is high and the clock has stopped,
  // so it is safe to sample here after the select has crossed
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pend_word <= '0;
    end else if (frame_end && full_sync) begin
      pend_word <= link_word;
    end
  end

  // A short frame is reported and discarded
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SHORT_WORD <= 1'b0;
    end else begin
      SHORT_WORD <= frame_end && !full_sync;
    end
  end

  // ----------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------

  // Offer holds until the buffer takes the word
  assign fill_bus.valid  = (state == ST_OFFER);
  assign fill_bus.data   = pend_word;
  assign drain_bus.ready = !CMD_STALL;

  // Two entries absorb a stall of the command stage
  word_buffer buffer (
    .clk   (REF_CLK),
    .rst   (RST),
    .fill  (fill_bus),
    .drain (drain_bus)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------

  // One command per accepted buffer word
  assign exec = drain_bus.valid && drain_bus.ready;
  assign cmd  = cmd_word_type'(drain_bus.data);

  // Completion pulse
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WORD_DONE <= 1'b0;
    end else begin
      WORD_DONE <= exec;
    end
  end

  // Input register contents after this cycle's command
  always_comb begin
    next_input = input_code;
    if (exec) begin
      if (cmd.ctrl_bit_lo) begin
        next_input[chan_index(cmd)] = cmd.dac_code_bits;
      end else if (!cmd.ctrl_bit_hi && !cmd.addr_bit_lo) begin
        next_input = {`CHANNELS{cmd.dac_code_bits}};
      end
    end
  end

  // Input registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      input_code <= {`CHANNELS{`CODE_RESET}};
    end else begin
      input_code <= next_input;
    end
  end

  // DAC registers: transparent under a low latch, otherwise only the
  // update, load-and-update and broadcast commands move them; feeding from next_input gives the
  // load-then-update order in one edge
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dac_code <= {`CHANNELS{`CODE_RESET}};
    end else if (!latch_sync) begin
      dac_code <= next_input;
    end else if (exec && cmd.ctrl_bit_hi) begin
      dac_code <= next_input;
    end else if (exec && ctrl_field(cmd) == `CTRL_BROADCAST && !cmd.addr_bit_lo) begin
      dac_code <= next_input;
    end
  end

  // Output edge selection
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode <= `MODE_RESET;
    end else if (exec && ctrl_field(cmd) == `CTRL_UPDATE && cmd.addr_bit_hi) begin
      mode <= cmd.addr_bit_lo;
    end
  end

  // Outputs straight from the registers
  assign ECHO_MODE  = mode;
  assign DAC_CODE_A = dac_code[0];
  assign DAC_CODE_B = dac_code[1];
  assign DAC_CODE_C = dac_code[2];
  assign DAC_CODE_D = dac_code[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Input load under a high latch leaves outputs alone
  chk_input_only: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && latch_sync && ctrl_field(cmd) == `CTRL_LOAD_INPUT |=> $stable(dac_code))
    else $error("input-only load moved a DAC register");

  // Address picks the loaded channel
  chk_channel_select: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && cmd.ctrl_bit_lo |=>
    input_code[$past(chan_index(cmd))] == $past(cmd.dac_code_bits))
    else $error("wrong channel loaded");

  // Load and update all
  chk_load_update: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && latch_sync && ctrl_field(cmd) == `CTRL_LOAD_UPDATE |=>
    dac_code == input_code)
    else $error("load-and-update left DACs behind");

  // Broadcast fills every register
  chk_broadcast_all: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && ctrl_field(cmd) == `CTRL_BROADCAST && !cmd.addr_bit_lo |=>
    dac_code == {`CHANNELS{$past(cmd.dac_code_bits)}} &&
    input_code == {`CHANNELS{$past(cmd.dac_code_bits)}})
    else $error("broadcast incomplete");

  // No-op keeps everything
  chk_nop_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && latch_sync && ctrl_field(cmd) == `CTRL_BROADCAST && cmd.addr_bit_lo |=>
    $stable(input_code) && $stable(dac_code))
    else $error("no-op changed a register");

  // Update all from inputs
  chk_update_all: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && ctrl_field(cmd) == `CTRL_UPDATE && !cmd.addr_bit_hi |=>
    dac_code == $past(input_code))
    else $error("update-all mismatch");

  // Rising-edge mode
  chk_mode_one: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && ctrl_field(cmd) == `CTRL_UPDATE && chan_index(cmd) == `ADDR_MODE1 |=>
    ECHO_MODE && dac_code == $past(input_code))
    else $error("mode 1 command failed");

  // Falling-edge mode
  chk_mode_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && ctrl_field(cmd) == `CTRL_UPDATE && chan_index(cmd) == `ADDR_MODE0 |=>
    !ECHO_MODE && dac_code == $past(input_code))
    else $error("mode 0 command failed");

  // Immediate update under a low latch
  chk_immediate: assert property (@(posedge REF_CLK) disable iff (RST)
    exec && !latch_sync && cmd.ctrl_bit_lo |=>
    dac_code[$past(chan_index(cmd))] == $past(cmd.dac_code_bits))
    else $error("low latch did not update channel");

  // Transparent latch
  chk_transparent: assert property (@(posedge REF_CLK) disable iff (RST)
    !latch_sync |=> dac_code == input_code)
    else $error("DAC not following input");

  // Held latch without a command
  chk_latched_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    latch_sync && !exec |=> $stable(dac_code))
    else $error("latched DAC changed");

  // Short frames dropped and flagged
  chk_short_word: assert property (@(posedge REF_CLK) disable iff (RST)
    frame_end && !full_sync |=> SHORT_WORD && state == ST_WAIT ##1 !fill_bus.valid)
    else $error("short word not dropped");

  // Full frame reaches the buffer offer
  chk_full_offer: assert property (@(posedge REF_CLK) disable iff (RST)
    frame_end && full_sync |=> fill_bus.valid && pend_word == $past(link_word))
    else $error("full word not offered");

  // Completion follows each command by one cycle
  chk_word_done: assert property (@(posedge REF_CLK) disable iff (RST)
    exec |=> WORD_DONE)
    else $error("missing completion pulse");

endmodule

// ---- rtl/dac_regs.svh ----
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH
// Word and field sizes
`define WORD_BITS 16
`define CODE_BITS 12
`define CHANNELS 4
// Reset values
`define CODE_RESET 12'h000
`define MODE_RESET 1'h1
// Control field encodings
`define CTRL_BROADCAST 2'h0
`define CTRL_LOAD_INPUT 2'h1
`define CTRL_UPDATE 2'h2
`define CTRL_LOAD_UPDATE 2'h3
// Address values that pick the output edge
`define ADDR_MODE1 2'h3
`define ADDR_MODE0 2'h2
// Bit counter of the link
`define COUNT_BITS 5
`define COUNT_ONE 5'h01
`define COUNT_FULL 5'h10
// Word buffer
`define BUF_DEPTH 2
`define BUF_FULL 2'h2
`endif

// ---- rtl/dac_pkg.sv ----
`include "dac_regs.svh"

package dac_pkg;
  // Raw serial word
  typedef logic [`WORD_BITS-1:0] word_type;
  // Field layout, first bit sent at the top
  typedef struct packed {
    logic                  addr_bit_hi;
    logic                  addr_bit_lo;
    logic                  ctrl_bit_hi;
    logic                  ctrl_bit_lo;
    logic [`CODE_BITS-1:0] dac_code_bits;
  } cmd_word_type;
  // Frame tracking in the reference domain
  typedef enum {ST_WAIT, ST_FRAME, ST_OFFER} cap_state_type;
endpackage

// ---- rtl/word_stream_if.sv ----
`timescale 1ns/1ps

interface word_stream_if;
  import dac_pkg::*;
  logic     valid;
  logic     ready;
  word_type data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/serial_link.sv ----
`timescale 1ns/1ps
`include "dac_regs.svh"

module serial_link
  import dac_pkg::*;
(
  // Link clock and reset
  input  wire logic shift_clk,
  input  wire logic rst,
  // Serial pins
  input  wire logic chip_select_n,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  // Toward the reference domain
  input  wire logic mode_ref,
  output word_type  word,
  output logic      word_full
);

  logic [`COUNT_BITS-1:0] count;
  logic                   fresh;
  logic                   frame_clr;
  logic                   mode_meta;
  logic                   mode_sync;
  logic                   rise_bit;
  logic                   fall_bit;

  // Shift register, only moves while selected
  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      word <= '0;
    end else if (!chip_select_n) begin
      word <= {word[`WORD_BITS-2:0], serial_in};
    end
  end

  // Set while deselected so the next frame restarts the count
  assign frame_clr = rst | chip_select_n;
  always_ff @(posedge shift_clk or posedge frame_clr) begin
    if (frame_clr) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Count survives deselect, so the other domain can read it after the frame
  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!chip_select_n) begin
      if (fresh) begin
        count <= `COUNT_ONE;
      end else if (count != `COUNT_FULL) begin
        count <= count + `COUNT_ONE;
      end
    end
  end
  assign word_full = (count == `COUNT_FULL);

  // Mode is quasi-static; first two edges of a frame still see the old one
  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      mode_meta <= `MODE_RESET;
      mode_sync <= `MODE_RESET;
    end else begin
      mode_meta <= mode_ref;
      mode_sync <= mode_meta;
    end
  end

  // Output stages give 16 or 16.5 cycles of lag
  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      rise_bit <= 1'b0;
    end else begin
      rise_bit <= word[`WORD_BITS-1];
    end
  end
  always_ff @(negedge shift_clk or posedge rst) begin
    if (rst) begin
      fall_bit <= 1'b0;
    end else begin
      fall_bit <= rise_bit;
    end
  end

  // Pin idles high while deselected
  assign serial_out    = chip_select_n ? 1'b1 : (mode_sync ? rise_bit : fall_bit);
  assign serial_out_oe = !chip_select_n;
endmodule

// ---- rtl/word_buffer.sv ----
`timescale 1ns/1ps
`include "dac_regs.svh"

module word_buffer
  import dac_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Filling and draining sides
  word_stream_if.snk fill,
  word_stream_if.src drain
);

  word_type   slot [`BUF_DEPTH];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  // Handshakes
  assign fill.ready  = (count != `BUF_FULL);
  assign drain.valid = (count != 2'h0);
  assign drain.data  = slot[rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // Storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot <= '{default: '0};
    end else if (push) begin
      slot[wr_ptr] <= fill.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- sim/host_serial_master.sv ----
`timescale 1ns/1ps

module host_serial_master (
  // Serial pins toward the device
  output logic      sclk,
  output logic      cs_n,
  output logic      ser_in,
  // Echo pin from the device
  input  wire logic ser_out,
  input  wire logic ser_out_oe
);
  logic        pin;
  logic [31:0] echo_rise;
  logic [31:0] echo_fall;

  // Open drain with pull-up, so a released echo line reads high
  assign pin = ser_out_oe ? ser_out : 1'b1;

  // Idle state: link clock stopped, this device not selected
  initial begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    ser_in    = 1'b1;
    echo_rise = 32'h0;
    echo_fall = 32'h0;
  end

  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  // Sends w[n-1:0] first bit on top; clock runs only inside the frame
  task automatic send(input logic [31:0] w, input int n);
    int i;
    #7;
    cs_n = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      ser_in = w[i];
      #40;
      echo_rise = {echo_rise[30:0], pin};
      sclk = 1'b1;
      #40;
      echo_fall = {echo_fall[30:0], pin};
      sclk = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    // Released data line must not keep looking valid
    ser_in = ~ser_in;
  endtask
endmodule

// ---- sim/test_dac_cmd_top.sv ----
`timescale 1ns/1ps
`include "dac_regs.svh"

module test_dac_cmd_top
  import dac_pkg::*;
;
  logic        ref_clk, rst, load_latch_n, cmd_stall;
  logic        sclk, cs_n, ser_in, ser_out, ser_out_oe;
  logic        word_done, short_word, out_mode;
  logic [11:0] dac_a, dac_b, dac_c, dac_d;
  logic [11:0] inp [4];
  logic [11:0] dac [4];
  logic        mode;
  int          failures, checked, cycles, dones, shorts, i, base;

  dac_cmd_top u_dut (
    .REF_CLK(ref_clk), .RST(rst), .SHIFT_CLK(sclk), .CHIP_SELECT_N(cs_n),
    .CHAIN_SERIAL_IN(ser_in), .CHAIN_SERIAL_OUT(ser_out), .CHAIN_SERIAL_OUT_OE(ser_out_oe),
    .LOAD_LATCH_N(load_latch_n), .CMD_STALL(cmd_stall), .WORD_DONE(word_done),
    .SHORT_WORD(short_word), .ECHO_MODE(out_mode), .DAC_CODE_A(dac_a),
    .DAC_CODE_B(dac_b), .DAC_CODE_C(dac_c), .DAC_CODE_D(dac_d)
  );

  host_serial_master u_host (
    .sclk(sclk), .cs_n(cs_n), .ser_in(ser_in), .ser_out(ser_out), .ser_out_oe(ser_out_oe)
  );

  // Reference clock, 100 ns period
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // Pulse counters and a hang guard well above the expected run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (word_done === 1'b1) dones <= dones + 1;
    if (short_word === 1'b1) shorts <= shorts + 1;
    if (cycles == 8000) begin
      failures = failures + 1;
      conclude();
    end
  end

  // ----------------------------------------
  // Checking and transfer tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // All four converter codes and the echo mode against the bench's own model
  task automatic chk_all();
    chk({4'h0, dac_a}, {4'h0, dac[0]});
    chk({4'h0, dac_b}, {4'h0, dac[1]});
    chk({4'h0, dac_c}, {4'h0, dac[2]});
    chk({4'h0, dac_d}, {4'h0, dac[3]});
    chk({15'h0, out_mode}, {15'h0, mode});
  endtask

  // Expected register effect of one decoded word
  task automatic model(input cmd_word_type c);
    logic [1:0] a;
    logic       upd;
    a   = {c.addr_bit_hi, c.addr_bit_lo};
    upd = ~load_latch_n;
    case ({c.ctrl_bit_hi, c.ctrl_bit_lo})
      `CTRL_LOAD_INPUT: inp[a] = c.dac_code_bits;
      `CTRL_LOAD_UPDATE: begin
        inp[a] = c.dac_code_bits;
        upd    = 1'b1;
      end
      `CTRL_BROADCAST: if (!c.addr_bit_lo) begin
        inp = '{4{c.dac_code_bits}};
        upd = 1'b1;
      end
      default: begin
        upd = 1'b1;
        if (a == `ADDR_MODE1) mode = 1'b1;
        if (a == `ADDR_MODE0) mode = 1'b0;
      end
    endcase
    if (upd) dac = inp;
  endtask

  // One frame, then a bounded wait for the command stage to report back
  task automatic xfer(input logic [31:0] w, input int n);
    int k;
    base = dones + shorts;
    u_host.send(w, n);
    for (k = 0; k < 12 && dones + shorts == base; k++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic cmd(input logic [15:0] w);
    xfer({16'h0, w}, 16);
    model(w);
  endtask

  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    load_latch_n = 1'b1;
    cmd_stall = 1'b0;
    failures = 0;
    checked = 0;
    cycles = 0;
    dones = 0;
    shorts = 0;
    inp = '{4{`CODE_RESET}};
    dac = '{4{`CODE_RESET}};
    mode = `MODE_RESET;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_all();
    chk({14'h0, ser_out, ser_out_oe}, 16'h0002);
    // Distinct code per channel so a wrong address shows up
    for (i = 0; i < 4; i++) cmd({i[1:0], `CTRL_LOAD_INPUT, 2'h2, i[1:0], 8'h5A});
    chk_all();
    cmd(16'h6ABC);
    chk_all();
    cmd(16'hB5A5);
    chk_all();
    cmd(16'h83C3);
    chk_all();
    cmd(16'h4FFF);
    chk_all();
    cmd(16'h1123);
    cmd(16'hA000);
    chk_all();
    // Long frame: a stale word shifts through, only the broadcast tail is decoded
    xfer({16'hC5A3, 16'h0321}, 32);
    model(16'h0321);
    chk({1'b0, u_host.echo_rise[14:0]}, 16'h62D1);
    chk(u_host.echo_fall[15:0], 16'h62D1);
    chk_all();
    cmd(16'h2777);
    cmd(16'hE000);
    chk_all();
    xfer({16'hC5A3, 16'h4000}, 32);
    chk(u_host.echo_fall[15:0], 16'hC5A3);
    // Frame cut short after twelve bits must change nothing
    xfer({20'h0, 12'h83C}, 12);
    chk(shorts[15:0], 16'h0001);
    chk_all();
    cmd(16'h1456);
    chk_all();
    @(posedge ref_clk);
    load_latch_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    dac = inp;
    chk_all();
    cmd(16'hD789);
    cmd(16'h7ABC);
    chk_all();
    @(posedge ref_clk);
    load_latch_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Two words queue while the command stage is stalled; none may be lost
    cmd_stall <= 1'b1;
    xfer({16'h0, 16'h1AAA}, 16);
    xfer({16'h0, 16'h7BBB}, 16);
    chk_all();
    @(posedge ref_clk);
    cmd_stall <= 1'b0;
    base = dones;
    for (i = 0; i < 20 && dones < base + 2; i++) @(posedge ref_clk);
    #1;
    model(16'h1AAA);
    model(16'h7BBB);
    chk_all();
    chk(dones[15:0], 16'h0013);
    conclude();
  end
endmodule
